// ---- slsc_defs.svh ----
// Constants for the front-panel status LED and switch controller
//
// Contract
// - Power LED: green, blink init, red standby, off
// - TX/RX LED red when radio power outside window; code: only while radioCarrier is high, else green
// - TX/RX LED green rx, blink tx, dark off
// - Sync LED green when synced and cable present
// - Sync LED blinks green awaiting power-cycle activation
// - Sync LED yellow blink, red error, else dark
// - Fault LED green, yellow blink GPS, red failure
// - Fault LED slow red blink on antenna fault
// - Fault LED fast red blink on cable fault
// - All LEDs yellow or red during erase sequences
// - Thirty second hold zeroizes, dark, then reboot
// - Zeroized unit refuses operation until reactivated
// - Continued hold to sixty seconds starts factory reset
// - Factory reset ends dark, reboots, needs configuration
// - LEDs shown while switch held momentary
// - Auto switch receive to transmit and back
// - Centre position powers on, starts startup
`ifndef SLSC_DEFS_SVH
`define SLSC_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define SLSC_CLK_PERIOD_NS 10
`define SLSC_TICK_NS 1000000
`define SLSC_TICK_CYCLES (`SLSC_TICK_NS / `SLSC_CLK_PERIOD_NS)
`define SLSC_WARN_MS 20000
`define SLSC_ZERO_MS 30000
`define SLSC_RED_MS 32000
`define SLSC_FACT_MS 60000
`define SLSC_BLINK_MS 250
`define SLSC_SLOW_MS 500
`define SLSC_FAST_MS 125

// ****************************************
// Radio input power window in mW
// ****************************************
`define SLSC_RF_W 12
`define SLSC_RF_MIN_MW 12'h014
`define SLSC_RF_MAX_MW 12'h7d0

// ****************************************
// Reset values
// ****************************************
`define SLSC_LOCK_RST 1'b0
`define SLSC_CFG_RST 1'b0

`endif

// ---- slsc_hold_timer.sv ----
// Saturating millisecond timer of how long the switch is held
`timescale 1ns/10ps
`default_nettype none
module slsc_hold_timer
	import slsc_pkg::*;
#(
	parameter int MAX_MS = 60000
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic msTick,
	input wire logic held,
	output logic [$clog2(MAX_MS+1)-1:0] holdMs
);
	localparam int HW = $clog2(MAX_MS + 1);
	localparam logic [HW-1:0] TOP = HW'(MAX_MS);

	// Saturation keeps a very long hold from wrapping back into the idle range
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			holdMs <= '0;
		else if (clkEn)
		begin
			if (!held)
				holdMs <= '0;
			else if (msTick && holdMs != TOP)
				holdMs <= holdMs + 1'b1;
		end
	end
endmodule // slsc_hold_timer
`default_nettype wire

// ---- slsc_operator.sv ----
// Operator at the three-position toggle switch
`timescale 1ns/10ps
`default_nettype none
module slsc_operator
(
	input wire logic clk,
	output var logic switchCentre,
	output var logic switchMomentary
);
	initial
	begin
		switchCentre = 1'b0;
		switchMomentary = 1'b0;
	end
	// Centre position powers the unit
	task powerUp(input logic on);
		@(posedge clk);
		switchCentre <= on;
	endtask
	// Momentary springs back to centre, so the unit never loses power
	task hold(input logic on);
		@(posedge clk);
		switchMomentary <= on;
		switchCentre <= !on;
	endtask
endmodule // slsc_operator
`default_nettype wire

// ---- slsc_pkg.sv ----
// Types shared by the status LED and switch controller
package slsc_pkg;
	typedef enum logic [1:0] {
		SLSC_OFF = 2'h0,
		SLSC_GREEN = 2'h1,
		SLSC_RED = 2'h2,
		SLSC_YELLOW = 2'h3
	} slsc_color_t;

	typedef enum logic [3:0] {
		PW_OFF = 4'h1,
		PW_INIT = 4'h2,
		PW_RUN = 4'h4,
		PW_STBY = 4'h8
	} slsc_power_t;

	typedef enum logic [5:0] {
		SQ_IDLE = 6'h01,
		SQ_WARN = 6'h02,
		SQ_ZDARK = 6'h04,
		SQ_RED = 6'h08,
		SQ_FDARK = 6'h10,
		SQ_REBOOT = 6'h20
	} slsc_seq_t;
endpackage

// ---- slsc_tick.sv ----
// Divider giving a step pulse and a toggling square wave
`timescale 1ns/10ps
`default_nettype none
module slsc_tick
	import slsc_pkg::*;
#(
	parameter int DIV = 2
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic stepEn,
	output logic tick,
	output logic level
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_r;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_r <= '0;
			tick <= 1'b0;
			level <= 1'b0;
		end
		else if (clkEn)
		begin
			tick <= 1'b0;
			if (stepEn)
			begin
				if (cnt_r == LAST)
				begin
					cnt_r <= '0;
					tick <= 1'b1;
					level <= ~level;
				end
				else
					cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule // slsc_tick
`default_nettype wire

// ---- slsc_top.sv ----
// Front-panel LED status and switch hold controller
`timescale 1ns/10ps
`default_nettype none
`include "slsc_defs.svh"
module slsc_top
	import slsc_pkg::*;
#(
	parameter int TICK_CYCLES = `SLSC_TICK_CYCLES,
	parameter int WARN_MS = `SLSC_WARN_MS,
	parameter int ZERO_MS = `SLSC_ZERO_MS,
	parameter int RED_MS = `SLSC_RED_MS,
	parameter int FACT_MS = `SLSC_FACT_MS,
	parameter int BLINK_MS = `SLSC_BLINK_MS,
	parameter int SLOW_MS = `SLSC_SLOW_MS,
	parameter int FAST_MS = `SLSC_FAST_MS
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic switchCentrePosition,
	input wire logic switchMomentaryPosition,
	input wire logic initDone,
	input wire logic standbyReq,
	input wire logic transceiverOn,
	input wire logic [`SLSC_RF_W-1:0] radioPowerMw,
	input wire logic radioCarrier,
	input wire logic channelMatch,
	input wire logic syncBusy,
	input wire logic syncDone,
	input wire logic syncPending,
	input wire logic syncError,
	input wire logic unconfigured,
	input wire logic lanLinked,
	input wire logic unitFailure,
	input wire logic gpsFixLost,
	input wire logic antennaFault,
	input wire logic cableFault,
	input wire logic reactivate,
	input wire logic firstConfigDone,
	output logic powerIndicatorGreen,
	output logic powerIndicatorRed,
	output logic trxLedGreen,
	output logic trxLedRed,
	output logic syncLedGreen,
	output logic syncLedRed,
	output logic faultLedGreen,
	output logic faultLedRed,
	output logic txModeActive,
	output logic zeroizeReq,
	output logic factoryResetReq,
	output logic rebootReq,
	output logic zeroizedLock,
	output logic firstConfigNeeded
);
	localparam int HW = $clog2(FACT_MS + 1);
	localparam logic [HW-1:0] WARN_T = HW'(WARN_MS);
	localparam logic [HW-1:0] ZERO_T = HW'(ZERO_MS);
	localparam logic [HW-1:0] RED_T = HW'(RED_MS);
	localparam logic [HW-1:0] FACT_T = HW'(FACT_MS);

	// ****************************************
	// Time base and blink sources
	// ****************************************
	logic msTick;
	logic blinkLvl;
	logic slowLvl;
	logic fastLvl;
	logic [HW-1:0] holdMs;
	logic powered;
	logic held;

	assign powered = switchCentrePosition | switchMomentaryPosition;
	assign held = switchMomentaryPosition;

	slsc_tick #(.DIV(TICK_CYCLES)) uMs (
		.clk(clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.stepEn(1'b1),
		.tick(msTick),
		.level()
	);

	slsc_tick #(.DIV(BLINK_MS)) uBlink (
		.clk(clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.stepEn(msTick),
		.tick(),
		.level(blinkLvl)
	);

	// Half periods of 500 ms and 125 ms: 1 Hz against 4 Hz
	slsc_tick #(.DIV(SLOW_MS)) uSlow (
		.clk(clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.stepEn(msTick),
		.tick(),
		.level(slowLvl)
	);

	slsc_tick #(.DIV(FAST_MS)) uFast (
		.clk(clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.stepEn(msTick),
		.tick(),
		.level(fastLvl)
	);

	slsc_hold_timer #(.MAX_MS(FACT_MS)) uHold (
		.clk(clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.msTick(msTick),
		.held(held & powered),
		.holdMs(holdMs)
	);

	// ****************************************
	// Switch hold sequence
	// ****************************************
	slsc_seq_t seq_r;
	slsc_seq_t seq_nxt;

	always_comb
	begin
		seq_nxt = seq_r;
		unique case (seq_r)
			SQ_IDLE:
				if (held && holdMs >= WARN_T)
					seq_nxt = SQ_WARN;
			SQ_WARN:
				if (!held)
					seq_nxt = SQ_IDLE;
				else if (holdMs >= ZERO_T)
					seq_nxt = SQ_ZDARK;
			SQ_ZDARK:
				if (!held)
					seq_nxt = SQ_REBOOT;
				else if (holdMs >= RED_T)
					seq_nxt = SQ_RED;
			SQ_RED:
				if (!held)
					seq_nxt = SQ_REBOOT;
				else if (holdMs >= FACT_T)
					seq_nxt = SQ_FDARK;
			SQ_FDARK:
				if (!held)
					seq_nxt = SQ_REBOOT;
			SQ_REBOOT:
				seq_nxt = SQ_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			seq_r <= SQ_IDLE;
		else if (clkEn)
			seq_r <= powered ? seq_nxt : SQ_IDLE;
	end

	// Request pulses last one enabled cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			zeroizeReq <= 1'b0;
			factoryResetReq <= 1'b0;
			rebootReq <= 1'b0;
		end
		else if (clkEn)
		begin
			zeroizeReq <= powered && seq_r == SQ_WARN && seq_nxt == SQ_ZDARK;
			factoryResetReq <= powered && seq_r == SQ_RED && seq_nxt == SQ_FDARK;
			rebootReq <= powered && seq_nxt == SQ_REBOOT;
		end
	end

	// Sticky locks: a new erase wins over a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			zeroizedLock <= `SLSC_LOCK_RST;
			firstConfigNeeded <= `SLSC_CFG_RST;
		end
		else if (clkEn)
		begin
			if (zeroizeReq)
				zeroizedLock <= 1'b1;
			else if (reactivate)
				zeroizedLock <= 1'b0;
			if (factoryResetReq)
				firstConfigNeeded <= 1'b1;
			else if (firstConfigDone)
				firstConfigNeeded <= 1'b0;
		end
	end

	// ****************************************
	// Power state
	// ****************************************
	slsc_power_t power_r;
	slsc_power_t power_nxt;
	logic blocked;

	// Erased units never reach the running state
	assign blocked = zeroizedLock | firstConfigNeeded;

	always_comb
	begin
		power_nxt = power_r;
		unique case (power_r)
			PW_OFF:
				power_nxt = PW_INIT;
			PW_INIT:
				if (initDone)
					power_nxt = (blocked || standbyReq) ? PW_STBY : PW_RUN;
			PW_RUN:
				if (blocked || standbyReq)
					power_nxt = PW_STBY;
			PW_STBY:
				if (!blocked && !standbyReq)
					power_nxt = PW_RUN;
		endcase
		if (!powered)
			power_nxt = PW_OFF;
		else if (rebootReq)
			power_nxt = PW_INIT;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			power_r <= PW_OFF;
		else if (clkEn)
			power_r <= power_nxt;
	end

	// ****************************************
	// Receive and transmit mode
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			txModeActive <= 1'b0;
		else if (clkEn)
		begin
			if (power_r != PW_RUN || !transceiverOn || !radioCarrier)
				txModeActive <= 1'b0;
			else if (channelMatch)
				txModeActive <= 1'b1;
		end
	end

	// ****************************************
	// Indicator colours
	// ****************************************
	slsc_color_t powerCol;
	slsc_color_t trxCol;
	slsc_color_t syncCol;
	slsc_color_t faultCol;
	logic rfBad;

	assign rfBad = radioPowerMw < `SLSC_RF_MIN_MW || radioPowerMw > `SLSC_RF_MAX_MW;

	always_comb
	begin
		powerCol = SLSC_OFF;
		trxCol = SLSC_OFF;
		syncCol = SLSC_OFF;
		faultCol = SLSC_OFF;
		unique case (power_r)
			PW_OFF:
				powerCol = SLSC_OFF;
			PW_INIT:
				powerCol = blinkLvl ? SLSC_GREEN : SLSC_OFF;
			PW_STBY:
				powerCol = SLSC_RED;
			PW_RUN:
			begin
				powerCol = SLSC_GREEN;
				if (!transceiverOn)
					trxCol = SLSC_OFF;
				else if (rfBad && radioCarrier)
					trxCol = SLSC_RED;
				else if (txModeActive)
					trxCol = blinkLvl ? SLSC_GREEN : SLSC_OFF;
				else
					trxCol = SLSC_GREEN;
				if (syncError || unconfigured)
					syncCol = SLSC_RED;
				else if (syncBusy)
					syncCol = blinkLvl ? SLSC_YELLOW : SLSC_OFF;
				else if (syncDone && syncPending)
					syncCol = blinkLvl ? SLSC_GREEN : SLSC_OFF;
				else if (syncDone && lanLinked)
					syncCol = SLSC_GREEN;
				else
					syncCol = SLSC_OFF;
				if (unitFailure)
					faultCol = SLSC_RED;
				else if (cableFault)
					faultCol = fastLvl ? SLSC_RED : SLSC_OFF;
				else if (antennaFault)
					faultCol = slowLvl ? SLSC_RED : SLSC_OFF;
				else if (gpsFixLost)
					faultCol = blinkLvl ? SLSC_YELLOW : SLSC_OFF;
				else
					faultCol = SLSC_GREEN;
			end
		endcase
		if (seq_r == SQ_WARN)
		begin
			powerCol = SLSC_YELLOW;
			trxCol = SLSC_YELLOW;
			syncCol = SLSC_YELLOW;
			faultCol = SLSC_YELLOW;
		end
		else if (seq_r == SQ_RED)
		begin
			powerCol = SLSC_RED;
			trxCol = SLSC_RED;
			syncCol = SLSC_RED;
			faultCol = SLSC_RED;
		end
	end

	// ****************************************
	// LED output registers
	// ****************************************
	logic show;

	// Hidden by default: status only lights while the switch sits in momentary
	assign show = powered && held && seq_r != SQ_ZDARK && seq_r != SQ_FDARK
		&& seq_r != SQ_REBOOT;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			powerIndicatorGreen <= 1'b0;
			powerIndicatorRed <= 1'b0;
			trxLedGreen <= 1'b0;
			trxLedRed <= 1'b0;
			syncLedGreen <= 1'b0;
			syncLedRed <= 1'b0;
			faultLedGreen <= 1'b0;
			faultLedRed <= 1'b0;
		end
		else if (clkEn)
		begin
			powerIndicatorGreen <= show & powerCol[0];
			powerIndicatorRed <= show & powerCol[1];
			trxLedGreen <= show & trxCol[0];
			trxLedRed <= show & trxCol[1];
			syncLedGreen <= show & syncCol[0];
			syncLedRed <= show & syncCol[1];
			faultLedGreen <= show & faultCol[0];
			faultLedRed <= show & faultCol[1];
		end
	end
endmodule // slsc_top
`default_nettype wire

// ---- slsc_top_asserts.sv ----
// Port checker for the status LED and switch controller
`timescale 1ns/10ps
`default_nettype none
module slsc_top_asserts
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic switchMomentaryPosition,
	input wire logic radioCarrier,
	input wire logic reactivate,
	input wire logic firstConfigDone,
	input wire logic powerIndicatorGreen,
	input wire logic powerIndicatorRed,
	input wire logic trxLedGreen,
	input wire logic trxLedRed,
	input wire logic syncLedGreen,
	input wire logic syncLedRed,
	input wire logic faultLedGreen,
	input wire logic faultLedRed,
	input wire logic txModeActive,
	input wire logic zeroizeReq,
	input wire logic factoryResetReq,
	input wire logic rebootReq,
	input wire logic zeroizedLock,
	input wire logic firstConfigNeeded
);
	// ****
	// Properties
	// ****
	wire logic [7:0] leds = {powerIndicatorGreen, powerIndicatorRed, trxLedGreen, trxLedRed,
		syncLedGreen, syncLedRed, faultLedGreen, faultLedRed};
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Two samples, in case the switch is resampled once
	a_dark_when_released: assert property ((clkEn && !switchMomentaryPosition)[*2] |=> leds == 8'h00)
		else $error("lit while released");
	a_yellow_all_four: assert property (leds[7:6] == 2'h3 |-> leds == 8'hff)
		else $error("partial yellow");
	a_red_power_alone: assert property (leds[7:6] == 2'h1 |-> leds == 8'h40 || leds == 8'h55)
		else $error("bad standby pattern");
	a_tx_ends_carrier: assert property (clkEn && !radioCarrier |=> !txModeActive)
		else $error("transmit without carrier");
	a_zeroize_locks: assert property (zeroizeReq |=> zeroizedLock && leds == 8'h00)
		else $error("zeroize not locked dark");
	a_zeroize_pulse: assert property (zeroizeReq && clkEn |=> !zeroizeReq)
		else $error("zeroize pulse too long");
	a_lock_sticky: assert property (zeroizedLock && !reactivate |=> zeroizedLock)
		else $error("lock dropped");
	a_factory_needs_cfg: assert property (factoryResetReq |=> firstConfigNeeded && leds == 8'h00)
		else $error("factory reset incomplete");
	a_cfg_sticky: assert property (firstConfigNeeded && !firstConfigDone |=> firstConfigNeeded)
		else $error("config flag dropped");
	a_reboot_pulse: assert property (rebootReq && clkEn |=> !rebootReq)
		else $error("reboot pulse too long");
	c_zero: cover property (zeroizeReq);
	c_fact: cover property (factoryResetReq);
	c_tx: cover property (txModeActive);
endmodule // slsc_top_asserts
bind slsc_top slsc_top_asserts i_asserts (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
	.switchMomentaryPosition(switchMomentaryPosition), .radioCarrier(radioCarrier),
	.reactivate(reactivate), .firstConfigDone(firstConfigDone),
	.powerIndicatorGreen(powerIndicatorGreen), .powerIndicatorRed(powerIndicatorRed),
	.trxLedGreen(trxLedGreen), .trxLedRed(trxLedRed), .syncLedGreen(syncLedGreen),
	.syncLedRed(syncLedRed), .faultLedGreen(faultLedGreen), .faultLedRed(faultLedRed),
	.txModeActive(txModeActive), .zeroizeReq(zeroizeReq), .factoryResetReq(factoryResetReq),
	.rebootReq(rebootReq), .zeroizedLock(zeroizedLock), .firstConfigNeeded(firstConfigNeeded));
`default_nettype wire

// ---- slsc_top_test.sv ----
// Self-checking bench for the status LED and switch controller
`timescale 1ns/10ps
`default_nettype none
module slsc_top_test;
	import slsc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clkEnable = 1'b1;
	logic initDone = 1'b0;
	logic standbyReq = 1'b0;
	logic transceiverOn = 1'b0;
	logic radioCarrier = 1'b0;
	logic channelMatch = 1'b0;
	logic syncBusy = 1'b0;
	logic syncDone = 1'b0;
	logic syncPending = 1'b0;
	logic syncError = 1'b0;
	logic unconfigured = 1'b0;
	logic lanLinked = 1'b0;
	logic unitFailure = 1'b0;
	logic gpsFixLost = 1'b0;
	logic antennaFault = 1'b0;
	logic cableFault = 1'b0;
	logic reactivate = 1'b0;
	logic firstConfigDone = 1'b0;
	logic [11:0] pw = 12'h064;
	wire logic cen;
	wire logic mom;
	wire logic [13:0] obs;
	int n_fail = 0;
	int compares = 0;
	int n;
	always #5 clk = ~clk;
	slsc_operator i_op (.clk(clk), .switchCentre(cen), .switchMomentary(mom));
	// Short counts: 1 ms is 4 clocks
	slsc_top #(.TICK_CYCLES(4), .WARN_MS(20), .ZERO_MS(30), .RED_MS(32), .FACT_MS(60),
		.BLINK_MS(4), .SLOW_MS(8), .FAST_MS(2)) i_dut (.clk(clk), .rst_n(rst_n),
		.clkEn(clkEnable), .switchCentrePosition(cen), .switchMomentaryPosition(mom),
		.initDone(initDone), .standbyReq(standbyReq), .transceiverOn(transceiverOn),
		.radioPowerMw(pw), .radioCarrier(radioCarrier), .channelMatch(channelMatch),
		.syncBusy(syncBusy), .syncDone(syncDone), .syncPending(syncPending),
		.syncError(syncError), .unconfigured(unconfigured), .lanLinked(lanLinked),
		.unitFailure(unitFailure), .gpsFixLost(gpsFixLost), .antennaFault(antennaFault),
		.cableFault(cableFault), .reactivate(reactivate), .firstConfigDone(firstConfigDone),
		.powerIndicatorGreen(obs[13]), .powerIndicatorRed(obs[12]), .trxLedGreen(obs[11]),
		.trxLedRed(obs[10]), .syncLedGreen(obs[9]), .syncLedRed(obs[8]),
		.faultLedGreen(obs[7]), .faultLedRed(obs[6]), .txModeActive(obs[5]),
		.zeroizeReq(obs[4]), .factoryResetReq(obs[3]), .rebootReq(obs[2]),
		.zeroizedLock(obs[1]), .firstConfigNeeded(obs[0]));
	// ****
	// Helpers
	// ****
	task complete_run;
		$display("mismatches %0d, compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task rng(input int v, input int lo, input int hi);
		chk((v >= lo && v <= hi) ? 16'(lo) : 16'(v), 16'(lo));
	endtask
	task cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task pwTry(input logic [11:0] p, input logic e);
		@(posedge clk);
		pw <= p;
		cyc(3);
		chk(16'(obs[10]), 16'(e));
	endtask
	// Re-press restarts the hold timer, keeping long looks below the warning
	task look;
		i_op.hold(1'b0);
		i_op.hold(1'b1);
		cyc(3);
	endtask
	task waitBit(input int b, output int c);
		#1;
		for (c = 0; obs[b] !== 1'b1; c++)
		begin
			cyc(1);
			if (c > 900)
			begin
				chk(16'(obs[b]), 16'h1);
				complete_run();
			end
		end
	endtask
	// Clocks between two toggles of one LED bit
	task half(input int b, output int c);
		logic v;
		v = obs[b];
		for (c = 0; c < 200 && obs[b] === v; c++)
			cyc(1);
		v = obs[b];
		for (c = 0; c < 200 && obs[b] === v; c++)
			cyc(1);
	endtask
	// ****
	// Scenarios
	// ****
	task t_boot;
		i_op.powerUp(1'b1);
		look();
		half(13, n);
		chk(16'(n), 16'h10);
		@(posedge clk);
		initDone <= 1'b1;
		transceiverOn <= 1'b1;
		syncDone <= 1'b1;
		lanLinked <= 1'b1;
		cyc(3);
		chk(16'(obs[13:6]), 16'haa);
		@(posedge clk);
		standbyReq <= 1'b1;
		cyc(3);
		chk(16'(obs[13:6]), 16'h40);
		@(posedge clk);
		standbyReq <= 1'b0;
		clkEnable <= 1'b0;
		cyc(8);
		chk(16'(obs[13:6]), 16'h40);
		@(posedge clk);
		clkEnable <= 1'b1;
		cyc(3);
		chk(16'(obs[13:6]), 16'haa);
		i_op.hold(1'b0);
		cyc(4);
		chk(16'(obs[13:6]), 16'h00);
	endtask
	task t_tx;
		look();
		@(posedge clk);
		radioCarrier <= 1'b1;
		cyc(3);
		chk(16'(obs[5]), 16'h0);
		@(posedge clk);
		channelMatch <= 1'b1;
		waitBit(5, n);
		rng(n, 0, 3);
		pwTry(12'h013, 1'b1);
		pwTry(12'h014, 1'b0);
		pwTry(12'h7d0, 1'b0);
		pwTry(12'h7d1, 1'b1);
		pwTry(12'h064, 1'b0);
		look();
		half(11, n);
		chk(16'(n), 16'h10);
		@(posedge clk);
		radioCarrier <= 1'b0;
		cyc(3);
		chk(16'(obs[11:10]), 16'h2);
		chk(16'(obs[5]), 16'h0);
		@(posedge clk);
		transceiverOn <= 1'b0;
		cyc(3);
		chk(16'(obs[11:10]), 16'h0);
		@(posedge clk);
		transceiverOn <= 1'b1;
	endtask
	task t_fault;
		@(posedge clk);
		unitFailure <= 1'b1;
		look();
		chk(16'(obs[7:6]), 16'h1);
		@(posedge clk);
		unitFailure <= 1'b0;
		gpsFixLost <= 1'b1;
		look();
		half(6, n);
		chk(16'(n), 16'h10);
		@(posedge clk);
		gpsFixLost <= 1'b0;
		antennaFault <= 1'b1;
		look();
		half(6, n);
		chk(16'(n), 16'h20);
		@(posedge clk);
		cableFault <= 1'b1;
		look();
		half(6, n);
		chk(16'(n), 16'h8);
		@(posedge clk);
		antennaFault <= 1'b0;
		cableFault <= 1'b0;
		cyc(3);
		chk(16'(obs[7:6]), 16'h2);
	endtask
	task t_sync;
		@(posedge clk);
		syncError <= 1'b1;
		look();
		chk(16'(obs[9:8]), 16'h1);
		@(posedge clk);
		syncError <= 1'b0;
		unconfigured <= 1'b1;
		cyc(3);
		chk(16'(obs[9:8]), 16'h1);
		@(posedge clk);
		unconfigured <= 1'b0;
		syncBusy <= 1'b1;
		look();
		half(8, n);
		chk(16'(n), 16'h10);
		@(posedge clk);
		syncBusy <= 1'b0;
		syncPending <= 1'b1;
		look();
		half(9, n);
		chk(16'(n), 16'h10);
		@(posedge clk);
		syncPending <= 1'b0;
		lanLinked <= 1'b0;
		cyc(3);
		chk(16'(obs[9:8]), 16'h0);
	endtask
	task t_erase;
		look();
		waitBit(12, n);
		rng(n, 70, 88);
		chk(16'(obs[13:6]), 16'hff);
		i_op.hold(1'b0);
		cyc(3);
		chk(16'(obs[4:0]), 16'h0);
		look();
		waitBit(12, n);
		rng(n, 70, 88);
		waitBit(4, n);
		rng(n, 36, 44);
		cyc(1);
		chk(16'(obs[13:6]), 16'h0);
		chk(16'(obs[1]), 16'h1);
		waitBit(12, n);
		rng(n, 4, 12);
		chk(16'(obs[13:6]), 16'h55);
		waitBit(3, n);
		rng(n, 104, 118);
		cyc(1);
		chk(16'({obs[13:6], obs[0]}), 16'h1);
		i_op.hold(1'b0);
		waitBit(2, n);
		rng(n, 0, 4);
		look();
		cyc(3);
		chk(16'(obs[13:6]), 16'h40);
		@(posedge clk);
		reactivate <= 1'b1;
		@(posedge clk);
		firstConfigDone <= 1'b1;
		cyc(2);
		chk(16'(obs[1:0]), 16'h0);
		cyc(2);
		chk(16'(obs[13:6]), 16'ha2);
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		cyc(1);
		chk(16'(obs), 16'h0);
		t_boot();
		t_tx();
		t_fault();
		t_sync();
		t_erase();
		complete_run();
	end
endmodule // slsc_top_test
`default_nettype wire
